// file: src/watch_timer_pkg.sv
// Constants shared by the watch and interval timer design files
package watch_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] MODE_INDEX = 32'h0000ff6f;
  localparam logic [31:0] BITOP_INDEX = 32'h0000ff70;
  localparam logic [31:0] STATUS_INDEX = 32'h0000ff71;
  localparam logic [31:0] MASK_INDEX = 32'h0000ff72;
  localparam logic [31:0] COUNT_INDEX = 32'h0000ff73;
  localparam logic [31:0] MODE_ADDR = MODE_INDEX << 2;
  localparam logic [31:0] BITOP_ADDR = BITOP_INDEX << 2;
  localparam logic [31:0] STATUS_ADDR = STATUS_INDEX << 2;
  localparam logic [31:0] MASK_ADDR = MASK_INDEX << 2;
  localparam logic [31:0] COUNT_ADDR = COUNT_INDEX << 2;

  // Mode register layout
  localparam int RUN_BIT = 0;
  localparam int SEC_BIT = 1;
  localparam int WSEL_LO = 2;
  localparam int ISEL_LO = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h7f;

  // Single-bit write register layout
  localparam int BITOP_POS_LO = 0;
  localparam int BITOP_VAL_BIT = 3;

  // Interrupt status and mask layout
  localparam int WATCH_EV_BIT = 0;
  localparam int INTERVAL_EV_BIT = 1;
  localparam logic [1:0] EVENT_RESET = 2'h0;

  // Watch clock is the system clock divided by two to this power
  localparam int WATCH_DIV_LOG2 = 7;
  localparam int PRESCALER_WIDTH = 11;
  localparam int COUNTER_WIDTH = 5;
  // Prescaler stage whose carry clocks the 5-bit counter
  localparam int COUNTER_TAP = 9;
  // Shortest interval period is two to this power watch cycles
  localparam int INTERVAL_BASE_LOG2 = 4;

  // Watch period select codes
  typedef enum logic [1:0] {
    WPERIOD_LONG,
    WPERIOD_HALF,
    WPERIOD_TAP5,
    WPERIOD_TAP4
  } watch_period_t;

endpackage

// file: src/watch_clock_divider.sv
// Divider that forms the one-cycle watch clock enable
`timescale 1ns/1ps
module watch_clock_divider
  import watch_timer_pkg::*;
#(
  parameter int DIV_LOG2 = WATCH_DIV_LOG2
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic watchTick
);

  logic [DIV_LOG2-1:0] divCount;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + 1'b1;
    end
  end

  // One pulse per wrap of the divider
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      watchTick <= 1'b0;
    end else begin
      watchTick <= (divCount == '1);
    end
  end

endmodule

// file: src/watch_prescaler_chain.sv
// Prescaler and 5-bit counter stepped by the watch clock enable
`timescale 1ns/1ps
module watch_prescaler_chain
  import watch_timer_pkg::*;
#(
  parameter int PRE_W = PRESCALER_WIDTH,
  parameter int CNT_W = COUNTER_WIDTH,
  parameter int CNT_TAP = COUNTER_TAP
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic watchTick,
  input wire logic runEnable,
  input wire logic secondsRun,
  output logic [PRE_W-1:0] prescaler,
  output logic [CNT_W-1:0] counter,
  output logic counterStep
);

  // Carry out of the prescaler stage that clocks the counter
  assign counterStep = watchTick && runEnable && (prescaler[CNT_TAP-1:0] == '1);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prescaler <= '0;
    end else if (!runEnable) begin
      prescaler <= '0;
    end else if (watchTick) begin
      prescaler <= prescaler + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      counter <= '0;
    end else if (!runEnable || !secondsRun) begin
      counter <= '0;
    end else if (counterStep) begin
      counter <= counter + 1'b1;
    end
  end

endmodule

// file: src/watch_interval_timer.sv
// Watch and interval timer with AHB-Lite registers, two request pulse outputs and one masked interrupt line
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module watch_interval_timer
  import watch_timer_pkg::*;
#(
  parameter int PRE_W = PRESCALER_WIDTH,
  parameter int CNT_W = COUNTER_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic watch_irq,
  output logic interval_irq,
  output logic irq
);

  // Mode register and interrupt registers
  logic [7:0] watch_mode_control;
  logic [1:0] eventStatus;
  logic [1:0] eventMask;

  // Decoded mode fields
  logic runEnable;
  logic secondsRun;
  watch_period_t watchPeriodSel;
  logic [2:0] intervalSel;

  // Timing chain
  logic watchTick;
  logic [PRE_W-1:0] prescaler;
  logic [CNT_W-1:0] counter;
  logic counterStep;
  logic [PRE_W-1:0] intervalMask;
  logic intervalHit;
  logic watchHit;

  // Bus data phase state
  logic dataWrite;
  logic [31:0] dataAddr;
  logic addrPhase;
  logic [31:0] next_hrdata;
  logic modeWrite;
  logic bitopWrite;
  logic statusWrite;
  logic maskWrite;
  logic [2:0] bitPos;
  logic [1:0] eventSet;

  assign runEnable = watch_mode_control[RUN_BIT];
  assign secondsRun = watch_mode_control[SEC_BIT];
  assign watchPeriodSel = watch_period_t'(watch_mode_control[WSEL_LO +: 2]);
  assign intervalSel = watch_mode_control[ISEL_LO +: 3];

  watch_clock_divider #(
    .DIV_LOG2(WATCH_DIV_LOG2)
  ) u_divider (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .watchTick(watchTick)
  );

  watch_prescaler_chain #(
    .PRE_W(PRE_W),
    .CNT_W(CNT_W),
    .CNT_TAP(COUNTER_TAP)
  ) u_chain (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .watchTick(watchTick),
    .runEnable(runEnable),
    .secondsRun(secondsRun),
    .prescaler(prescaler),
    .counter(counter),
    .counterStep(counterStep)
  );

  // Low bits of the prescaler that make up one interval period
  always_comb begin
    intervalMask = ~({PRE_W{1'b1}} << (INTERVAL_BASE_LOG2 + int'(intervalSel)));
  end

  // Interval event on the watch tick that completes the period
  always_comb begin
    intervalHit = watchTick && runEnable &&
                  ((prescaler & intervalMask) == intervalMask);
  end

  // Watch event from counter carries or short prescaler taps
  always_comb begin
    watchHit = 1'b0;
    if (runEnable && secondsRun) begin
      unique case (watchPeriodSel)
        WPERIOD_LONG: begin
          watchHit = counterStep && (counter == '1);
        end
        WPERIOD_HALF: begin
          watchHit = counterStep && (counter[CNT_W-2:0] == '1);
        end
        WPERIOD_TAP5: begin
          watchHit = watchTick && (prescaler[4:0] == 5'h1f);
        end
        WPERIOD_TAP4: begin
          watchHit = watchTick && (prescaler[3:0] == 4'hf);
        end
      endcase
    end
  end

  // Request pulses, one cycle each
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      watch_irq <= 1'b0;
    end else begin
      watch_irq <= watchHit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      interval_irq <= 1'b0;
    end else begin
      interval_irq <= intervalHit;
    end
  end

  // Address phase capture
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dataWrite <= 1'b0;
      dataAddr <= '0;
    end else if (hready) begin
      dataWrite <= addrPhase && hwrite;
      dataAddr <= {haddr[31:2], 2'b00};
    end
  end

  assign modeWrite = dataWrite && (dataAddr == MODE_ADDR);
  assign bitopWrite = dataWrite && (dataAddr == BITOP_ADDR);
  assign statusWrite = dataWrite && (dataAddr == STATUS_ADDR);
  assign maskWrite = dataWrite && (dataAddr == MASK_ADDR);
  assign bitPos = hwdata[BITOP_POS_LO +: 3];

  // Mode register: whole byte or one bit at a time
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      watch_mode_control <= MODE_RESET;
    end else if (modeWrite) begin
      watch_mode_control <= hwdata[7:0] & MODE_WMASK;
    end else if (bitopWrite && (bitPos != 3'h7)) begin
      watch_mode_control[bitPos] <= hwdata[BITOP_VAL_BIT];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  assign eventSet = {intervalHit, watchHit};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      eventStatus <= EVENT_RESET;
    end else begin
      eventStatus <= (eventStatus & ~(statusWrite ? hwdata[1:0] : 2'b00)) | eventSet;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      eventMask <= EVENT_RESET;
    end else if (maskWrite) begin
      eventMask <= hwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventStatus & eventMask);
    end
  end

  // Read data is prepared during the address phase
  always_comb begin
    next_hrdata = 32'h00000000;
    unique case ({haddr[31:2], 2'b00})
      MODE_ADDR: begin
        next_hrdata = {24'h000000, watch_mode_control};
      end
      STATUS_ADDR: begin
        next_hrdata = {30'h00000000, eventStatus};
      end
      MASK_ADDR: begin
        next_hrdata = {30'h00000000, eventMask};
      end
      COUNT_ADDR: begin
        next_hrdata = 32'({counter, prescaler});
      end
      default: begin
        next_hrdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

// file: testbench/watch_timer_sva.sv
// Checker for the timer bus answers and event outputs
`timescale 1ns/1ps
module watch_timer_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic watch_irq,
  input wire logic interval_irq,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic taken;
  logic wrTaken;
  logic [11:0] iGap;
  logic [11:0] wGap;
  assign taken = hsel && htrans[1] && hready;
  assign wrTaken = taken && hwrite;
  // Cycles since the last pulse of each event
  always_ff @(posedge sys_clk) begin
    if (!rstn || interval_irq) begin
      iGap <= 12'h000;
    end else if (iGap != 12'hfff) begin
      iGap <= iGap + 12'h001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn || watch_irq) begin
      wGap <= 12'h000;
    end else if (wGap != 12'hfff) begin
      wGap <= wGap + 12'h001;
    end
  end
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay;
    taken |=> !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_wpulse;
    watch_irq |=> !watch_irq [*8];
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("watch pulse too long");
  property p_ipulse;
    interval_irq |=> !interval_irq [*8];
  endproperty
  a_ipulse: assert property (p_ipulse) else $error("interval pulse too long");
  property p_igap;
    interval_irq |-> iGap >= 12'd1900;
  endproperty
  a_igap: assert property (p_igap) else $error("interval pulses too close");
  property p_wgap;
    watch_irq |-> wGap >= 12'd127;
  endproperty
  a_wgap: assert property (p_wgap) else $error("watch pulses too close");
  property p_hold;
    !(taken && !hwrite) |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_irqfall;
    $fell(irq) |-> $past(wrTaken, 2) || $past(wrTaken, 3) || $past(wrTaken, 4);
  endproperty
  a_irqfall: assert property (p_irqfall) else $error("irq fell unasked");
endmodule
bind watch_interval_timer watch_timer_sva chk (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .watch_irq(watch_irq), .interval_irq(interval_irq), .irq(irq));

// file: testbench/watch_interval_timer_test.sv
// Self-checking bench for the watch and interval timer
`timescale 1ns/1ps
module watch_interval_timer_test;
  import watch_timer_pkg::*;
  logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, m;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, watch_irq, interval_irq, irq;
  int n_errors = 0, comparisons = 0, cycles = 0, seed = 32'h9ed4, n;
  watch_interval_timer dut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .watch_irq(watch_irq),
    .interval_irq(interval_irq), .irq(irq));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Cycles from the previous edge to the next pulse land in n
  task automatic pulse(input bit w);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((w ? watch_irq : interval_irq) !== 1'b1);
  endtask
  task automatic quiet(input bit w);
    int k;
    k = 0;
    repeat (3000) begin
      @(posedge sys_clk);
      if ((w ? watch_irq : interval_irq) === 1'b1) k++;
    end
    chk("quiet", k, 0);
  endtask
  function automatic logic [31:0] ivLen(input int s);
    return 32'h80 << (4 + s);
  endfunction
  function automatic logic [31:0] wdLen(input int c);
    return 32'h80 << (c == 0 ? 14 : c == 1 ? 13 : c == 2 ? 5 : 4);
  endfunction
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(0, MODE_ADDR, 0); chk("mode", r, 0);
    bus(0, STATUS_ADDR, 0); chk("status", r, 0);
    bus(0, MODE_ADDR + 32'h40, 0); chk("unmapped", r, 0);
    m = $random(seed) & 32'h7e;
    bus(1, MODE_ADDR, m);
    bus(0, MODE_ADDR, 0); chk("modebyte", r, m);
    bus(1, MODE_ADDR, 0);
    // Interval bits first, so they never change while running
    for (int b = 6; b >= 0; b--) begin
      bus(1, BITOP_ADDR, 32'h8 | b);
      bus(0, MODE_ADDR, 0); chk("bitset", r, 32'h80 - (32'h1 << b));
    end
    bus(1, BITOP_ADDR, 32'h0);
    bus(0, MODE_ADDR, 0); chk("bitclr", r, 32'h7e);
    bus(0, COUNT_ADDR, 0); chk("count", r, 0);
    for (int s = 0; s < 3; s++) begin
      bus(1, MODE_ADDR, 0);
      bus(1, MODE_ADDR, (s << 4) | 1);
      pulse(0);
      pulse(0); chk("interval", n, ivLen(s));
    end
    bus(0, COUNT_ADDR, 0); chk("counter", 32'(r[15:11]), 0);
    bus(1, MODE_ADDR, 0);
    bus(1, MODE_ADDR, 32'h0d);
    quiet(1);
    for (int c = 2; c < 4; c++) begin
      bus(1, MODE_ADDR, 0);
      bus(1, MODE_ADDR, (c << 2) | 3);
      pulse(1);
      pulse(1); chk("watch", n, wdLen(c));
    end
    bus(1, MODE_ADDR, 32'h0d);
    bus(0, COUNT_ADDR, 0); chk("zerosec", 32'(r[15:11]), 0);
    // Two short watch periods of ticks stay in the prescaler
    chk("prekeep", 32'(r[10:0]), 32'h20);
    bus(1, MODE_ADDR, 0);
    quiet(0);
    bus(1, MODE_ADDR, 1);
    pulse(0);
    bus(1, MODE_ADDR, 0);
    bus(0, STATUS_ADDR, 0); chk("sticky", r, 3);
    chk("irqoff", irq, 0);
    m = ($random(seed) & 32'h3) | 32'h1;
    bus(1, MASK_ADDR, m);
    repeat (2) @(posedge sys_clk);
    chk("irqon", irq, 1);
    bus(1, STATUS_ADDR, 1);
    repeat (2) @(posedge sys_clk);
    chk("irqpart", irq, m[1]);
    bus(1, STATUS_ADDR, 2);
    bus(0, STATUS_ADDR, 0); chk("cleared", r, 0);
    chk("irqclr", irq, 0);
    wrap_up();
  end
endmodule
